/* File: hdl/fpu_delay_slot_hazard_control.sv */
// Delay-slot tracking, parallel-issue operand capture and hazard reporting
// for a floating-point unit behind a host pipeline.
// Assumes the host presents one instruction per advancing cycle and holds
// it, with stall_i high, for as long as its own pipeline is stalled.
`timescale 1ns/1ps
module fpu_delay_slot_hazard_control #(
   parameter int unsigned SLOTS = 1
) (
   input  wire logic                  ref_clk_i,
   input  wire logic                  nrst_i,
   input  wire logic                  stall_i,
   input  wire fpu_slot_pkg::instr_s  instr_i,
   output      fpu_slot_pkg::hazard_s hazard_o,
   output      logic [7:0]            reg_valid_o,
   output      fpu_slot_pkg::word_t   rd_data_o [8]
);
   import fpu_slot_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   word_t      regs_reg [REG_COUNT];
   logic [1:0] pend_reg [REG_COUNT];
   word_t      math_res_reg;
   reg_idx_t   math_dst_reg;
   logic       math_busy_reg;
   hazard_s    hazard_reg;
   // Per-register valid flags kept as flops so reg_valid_o needs no gate
   // behind the pending counters; they clear and set on the same edges.
   logic [REG_COUNT-1:0] valid_reg;

   wire logic advance = instr_i.valid & ~stall_i;

   // Simple datapath: the "math" result is a sum of captured operands
   // (stand-in arithmetic, the slot timing is what this block owns)
   function automatic logic pending(input logic [1:0] cnt);
      return cnt != SLOT_NONE;
   endfunction

   // ----------------------------------------------------------------
   // Operand capture, taken from state before any write this cycle
   // ----------------------------------------------------------------
   wire word_t a1  = regs_reg[instr_i.first.src_a];
   wire word_t b1  = regs_reg[instr_i.first.src_b];
   wire word_t a2  = regs_reg[instr_i.second.src_a];
   wire word_t mv2 = instr_i.second.rd_a_en ? a2 : instr_i.second.imm;
   wire word_t mv1 = instr_i.first.rd_a_en ? a1 : instr_i.first.imm;
   wire logic  f_math = instr_i.first.kind == OP_MATH;
   wire logic  s_move = instr_i.par_en & instr_i.second.wr_en;

   // Hazard decode against pending writes from earlier slots, and between the two halves for same_dst
   wire logic src_hit = (instr_i.first.rd_a_en & pending(pend_reg[instr_i.first.src_a]))
                      | (instr_i.first.rd_b_en & pending(pend_reg[instr_i.first.src_b]))
                      | (instr_i.par_en & instr_i.second.rd_a_en
                         & pending(pend_reg[instr_i.second.src_a]));
   wire logic dst_hit = (instr_i.first.wr_en & pending(pend_reg[instr_i.first.dst]))
                      | (s_move & pending(pend_reg[instr_i.second.dst]));
   wire logic flg_hit = math_busy_reg & ((instr_i.first.kind == OP_FLAG)
                      | (instr_i.par_en & instr_i.second.kind == OP_FLAG));
   wire logic same_dst = instr_i.par_en & instr_i.first.wr_en & s_move
                       & (instr_i.first.dst == instr_i.second.dst);
   wire hazard_s haz_next = advance ? '{dst_conflict: dst_hit, src_conflict: src_hit,
                                        flag_conflict: flg_hit, par_same_dst: same_dst}
                                    : '0;

   // ----------------------------------------------------------------
   // Pending counters and register writes
   // ----------------------------------------------------------------
   // Both halves launch in one advance; a math result retires one slot later.
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         for (int i = 0; i < REG_COUNT; i++) begin
            regs_reg[i] <= '0;
            pend_reg[i] <= SLOT_NONE;
         end
         math_res_reg  <= '0;
         math_dst_reg  <= '0;
         math_busy_reg <= 1'b0;
         valid_reg     <= '1;
      end else if (advance) begin
         // Retire the math op started last slot
         if (math_busy_reg) begin
            regs_reg[math_dst_reg]  <= math_res_reg;
            pend_reg[math_dst_reg]  <= SLOT_NONE;
            valid_reg[math_dst_reg] <= 1'b1;
         end
         math_busy_reg <= f_math & instr_i.first.wr_en;
         // A new math op on the retiring register wins: its clear comes last
         if (f_math & instr_i.first.wr_en) begin
            math_res_reg <= word_t'(a1 + b1);             // Carry dropped on purpose
            math_dst_reg <= instr_i.first.dst;
            pend_reg[instr_i.first.dst]  <= MATH_SLOTS;
            valid_reg[instr_i.first.dst] <= 1'b0;
         end else if (instr_i.first.wr_en) begin
            regs_reg[instr_i.first.dst] <= mv1;
         end
         // Single-cycle half lands now, a slot ahead of the math half
         if (s_move) begin
            regs_reg[instr_i.second.dst] <= mv2;
         end
      end
   end

   // Outputs are registered
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         hazard_reg <= '0;
      end else begin
         hazard_reg <= haz_next;
      end
   end

   assign hazard_o    = hazard_reg;
   assign reg_valid_o = valid_reg;                      // Straight from flops
   for (genvar g = 0; g < REG_COUNT; g++) begin : g_out
      assign rd_data_o[g] = regs_reg[g];
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // Math launch on an advancing edge
   sequence s_math_issue;
      advance && f_math && instr_i.first.wr_en;
   endsequence

   // Retiring edge with no delay-slot write to the same register
   sequence s_retire_edge;
      advance && math_busy_reg && !dst_hit;
   endsequence

   // The destination reads as pending right after launch
   a_math_pending: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      s_math_issue |=> !reg_valid_o[$past(instr_i.first.dst)])
      else $error("math destination valid too early");
   // The result lands in the register file on the next advancing edge
   a_math_retire: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      s_math_issue ##1 s_retire_edge |=>
         rd_data_o[$past(math_dst_reg)] == $past(math_res_reg))
      else $error("math result not written on retire");
   // Valid returns one slot later unless a new math op reclaims the register
   a_retire_slot: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      (math_busy_reg && advance) |=> reg_valid_o[$past(math_dst_reg)]
         || (math_busy_reg && math_dst_reg == $past(math_dst_reg)))
      else $error("math result not valid after one slot");
   // A stalled or empty slot freezes slot counting
   a_stall_hold: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      !advance |=> $stable(math_busy_reg) && $stable(reg_valid_o))
      else $error("pipeline moved during stall");
   // The move half is valid while the math half still pends
   a_move_first: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      (advance && s_move && f_math && !same_dst) |=>
         reg_valid_o[$past(instr_i.second.dst)])
      else $error("move half not valid ahead of math half");
   // The math half uses operands captured before the move half writes
   a_old_operand: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      (s_math_issue && s_move) |=>
         math_res_reg == word_t'($past(a1) + $past(b1)))
      else $error("first half used updated operand");
   // The move half reads the register as it stood before this slot
   a_move_oldval: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      (advance && s_move && instr_i.second.rd_a_en && !same_dst) |=>
         regs_reg[$past(instr_i.second.dst)] == $past(a2))
      else $error("second half did not read old value");
   // ----------------------------------------------------------------
   // Hazard reporting checks
   // ----------------------------------------------------------------
   // Each conflict kind is flagged one cycle after its advance
   a_src_hazard: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      (advance && src_hit) |=> hazard_o.src_conflict)
      else $error("source conflict not reported");
   a_dst_hazard: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      (advance && dst_hit) |=> hazard_o.dst_conflict)
      else $error("destination conflict not reported");
   a_flag_hazard: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      (advance && flg_hit) |=> hazard_o.flag_conflict)
      else $error("flag conflict not reported");
   a_same_dst: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      (advance && same_dst) |=> hazard_o.par_same_dst)
      else $error("parallel same destination not reported");
   // No report may stand after a slot that did not advance
   a_quiet_stall: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      !advance |=> hazard_o == '0)
      else $error("hazard reported without an advance");
   // A flag conflict needs a math op in flight
   a_flag_cause: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      (advance && !math_busy_reg) |=> !hazard_o.flag_conflict)
      else $error("flag conflict with nothing pending");

endmodule // fpu_delay_slot_hazard_control

/* File: hdl/fpu_slot_pkg.sv */
// Package for the floating-point delay-slot hazard controller.
// Assumes a single host clock domain; no software-visible registers.
package fpu_slot_pkg;

   // ----------------------------------------------------------------
   // Register file shape
   // ----------------------------------------------------------------
   localparam int unsigned REG_COUNT = 8;          // Result registers zero to seven
   localparam int unsigned IDX_W     = 3;
   localparam int unsigned DATA_W    = 32;
   typedef logic [IDX_W-1:0]  reg_idx_t;
   typedef logic [DATA_W-1:0] word_t;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam logic [1:0] MATH_SLOTS = 2'h1;       // Delay slots of a 2p math op
   localparam logic [1:0] SLOT_NONE  = 2'h0;

   // Operation kinds
   typedef enum logic [4:0] {
      OP_NONE       = 5'h01,
      OP_MOVE       = 5'h02,   // Single-cycle word_move_op
      OP_MATH       = 5'h04,   // 2p float_multiply_op / float_add_op / float_subtract_op
      OP_FLAG       = 5'h08,   // flag_set_op, status_move_op, save, restore
      OP_OTHER      = 5'h10    // Single-cycle non-math op
   } op_kind_e;

   // One operation half of an issued instruction
   typedef struct packed {
      op_kind_e kind;
      logic     wr_en;
      reg_idx_t dst;
      logic     rd_a_en;
      reg_idx_t src_a;
      logic     rd_b_en;
      reg_idx_t src_b;
      word_t    imm;       // Operand value for moves from memory
   } op_s;

   // Issued instruction: first half plus optional parallel half
   typedef struct packed {
      logic valid;
      op_s  first;
      logic par_en;
      op_s  second;
   } instr_s;

   // Hazard report
   typedef struct packed {
      logic dst_conflict;
      logic src_conflict;
      logic flag_conflict;
      logic par_same_dst;
   } hazard_s;

endpackage : fpu_slot_pkg

/* File: test/host_stall_model.sv */
// Host pipeline stand-in that inserts wait states on the stall line.
// Assumes the bench drives the instruction stream itself.
`timescale 1ns/1ps
module host_stall_model (
   input  wire logic ref_clk_i,
   input  wire logic hold_i,
   output      logic stall_o
);
   // ----------------------------------------------------------------
   // Stall source
   // ----------------------------------------------------------------
   int seed = 32'hb62d;
   initial stall_o = 1'b0;
   // Random wait states; the delay lets hold_i settle first
   always @(negedge ref_clk_i) begin
      #1 stall_o = hold_i | ($random(seed) % 4 == 0);
   end
endmodule // host_stall_model

/* File: test/tb_fpu_delay_slot_hazard_control.sv */
// Self-checking bench for the delay-slot hazard controller.
// Assumes one clock; stalls come from the host stall model.
`timescale 1ns/1ps
module tb_fpu_delay_slot_hazard_control;
   import fpu_slot_pkg::*;
   logic       ref_clk_i = 1'b0, nrst_i = 1'b0, stall_i, hold = 1'b0, adv = 1'b0;
   instr_s     instr_i = '0;
   hazard_s    hazard_o;
   logic [7:0] reg_valid_o;
   word_t      rd_data_o [8];
   word_t      v [4];
   op_s        nop, slot [3];
   logic [3:0] notes [$];
   logic [3:0] slot_h [3] = '{4'h8, 4'h4, 4'h2};
   int         seed = 32'hb62d, n_mismatch = 0, check_count = 0, cyc = 0;
   initial forever #4 ref_clk_i = ~ref_clk_i;
   host_stall_model model (.ref_clk_i(ref_clk_i), .hold_i(hold), .stall_o(stall_i));
   fpu_delay_slot_hazard_control dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
      .stall_i(stall_i), .instr_i(instr_i), .hazard_o(hazard_o),
      .reg_valid_o(reg_valid_o), .rd_data_o(rd_data_o));
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Source a of zero on a move means an immediate operand
   function automatic op_s op(op_kind_e k, reg_idx_t d, reg_idx_t a, word_t x);
      op = '{k, k inside {OP_MOVE, OP_MATH}, d, k == OP_MATH || a != 3'h0, a,
             k == OP_MATH, 3'h0, x};
   endfunction
   task automatic chk(string nm, word_t e, word_t s);
      check_count++;
      if (s !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Hold the instruction until an advancing edge takes it
   task automatic issue(op_s a, logic p, op_s b, logic [3:0] h);
      instr_i = '{1'b1, a, p, b};
      notes.push_back(h);
      @(posedge ref_clk_i);
      while (stall_i) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Hazard monitor and timeout
   // ----------------------------------------------------------------
   always @(posedge ref_clk_i) adv <= instr_i.valid && !stall_i && nrst_i;
   // Hazard flags stand one cycle, so each advance is checked once
   always @(negedge ref_clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         finish_test();
      end
      if (adv) chk("hazard", {28'h0, notes.pop_front()}, {28'h0, hazard_o});
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      foreach (v[i]) v[i] = $random(seed);
      nop = op(OP_NONE, 3'h0, 3'h0, 32'h0);
      slot[0] = op(OP_MOVE, 3'h6, 3'h0, v[3]);
      slot[1] = op(OP_MATH, 3'h3, 3'h6, 32'h0);
      slot[2] = op(OP_FLAG, 3'h0, 3'h0, 32'h0);
      repeat (2) @(negedge ref_clk_i);
      nrst_i = 1'b1;
      chk("valid", 32'hff, {24'h0, reg_valid_o});
      chk("r3", 32'h0, rd_data_o[3]);
      issue(op(OP_MOVE, 3'h0, 3'h0, v[0]), 1'b0, nop, 4'h0);
      issue(op(OP_MOVE, 3'h1, 3'h0, v[1]), 1'b0, nop, 4'h0);
      chk("r1", v[1], rd_data_o[1]);
      issue(op(OP_MATH, 3'h2, 3'h1, 0), 1'b1, op(OP_MOVE, 3'h1, 3'h0, v[2]), 4'h0);
      chk("valid2", 32'h0, {31'h0, reg_valid_o[2]});
      chk("r1 move", v[2], rd_data_o[1]);
      // Delay slot held by a stall: the math result must not retire
      hold = 1'b1;
      instr_i = '{1'b1, op(OP_MOVE, 3'h4, 3'h0, v[3]), 1'b0, nop};
      repeat (3) @(negedge ref_clk_i);
      chk("valid2 stall", 32'h0, {31'h0, reg_valid_o[2]});
      hold = 1'b0;
      issue(op(OP_MOVE, 3'h4, 3'h0, v[3]), 1'b0, nop, 4'h0);
      chk("r2 sum", v[0] + v[1], rd_data_o[2]);
      issue(op(OP_MATH, 3'h5, 3'h1, 0), 1'b1, op(OP_MOVE, 3'h6, 3'h5, 0), 4'h0);
      chk("r6 old", 32'h0, rd_data_o[6]);
      for (int i = 0; i < 3; i++) begin
         issue(op(OP_MATH, 3'h6, 3'h1, 0), 1'b0, nop, 4'h0);
         issue(slot[i], 1'b0, nop, slot_h[i]);
      end
      issue(op(OP_MATH, 3'h7, 3'h1, 0), 1'b1, op(OP_MOVE, 3'h7, 3'h0, v[0]), 4'h1);
      instr_i.valid = 1'b0;
      repeat (3) @(negedge ref_clk_i);
      finish_test();
   end
endmodule // tb_fpu_delay_slot_hazard_control
